// *** src/scgu_pkg.sv ***
// Package with register map, field layouts and encodings of the clock generation unit.
`default_nettype none
package scgu_pkg;
   // ****************************************************************
   // Register map, word aligned byte addresses
   // ****************************************************************
   localparam int          ADR_W            = 8;
   localparam logic [7:0]  OFS_OUT_HALVE    = 8'h00;
   localparam logic [7:0]  OFS_UNIT_RATIO   = 8'h04;
   localparam logic [7:0]  OFS_LB_DIVIDER   = 8'h08;
   localparam logic [7:0]  OFS_STATUS       = 8'h0c;
   localparam logic [7:0]  OFS_RATIOS       = 8'h10;

   // ****************************************************************
   // Unit clock ratio encodings and defaults
   // ****************************************************************
   localparam int          NUM_UNITS        = 7;
   localparam int          UNIT_PCI         = 6;
   localparam logic [1:0]  RATIO_OFF        = 2'h0;
   localparam logic [1:0]  RATIO_FULL       = 2'h1;
   localparam logic [1:0]  RATIO_HALF       = 2'h2;
   localparam logic [1:0]  RATIO_THIRD      = 2'h3;
   localparam logic [13:0] UNIT_RATIO_RST   = 14'h1fff;
   localparam logic [2:0]  PHASE_LAST       = 3'h5;
   localparam logic [2:0]  PHASE_THIRD      = 3'h3;

   // ****************************************************************
   // Local bus divider encodings
   // ****************************************************************
   localparam logic [1:0]  LB_DIV2          = 2'h0;
   localparam logic [1:0]  LB_DIV4          = 2'h1;
   localparam logic [1:0]  LB_DIV8          = 2'h2;
   localparam logic [2:0]  LB_CNT_LAST      = 3'h7;

   // ****************************************************************
   // System PLL multiplier decode
   // ****************************************************************
   localparam logic [3:0]  SYSTEM_PLL_MULTIPLIER_X16         = 4'h0;
   localparam logic [3:0]  SYSTEM_PLL_MULTIPLIER_RSVD        = 4'h1;
   localparam logic [4:0]  MULT_16          = 5'h10;

   // Fields of the low reset configuration word, bit 31 first.
   typedef struct packed {
      logic       lbiu_doubler;
      logic       mem_doubler;
      logic [1:0] spare_a;
      logic [3:0] system_pll_multiplier;
      logic       spare_b;
      logic [6:0] core_pll;
      logic [15:0] spare_c;
   } scgu_rcw_t;

   // Status word layout as read by software.
   typedef struct packed {
      logic [8:0] zero_hi;
      logic [6:0] core_pll;
      logic       zero_lo;
      logic       halve_strap;
      logic       host_role;
      logic       running;
      logic       mem_doubler;
      logic       lbiu_doubler;
      logic       system_pll_multiplier_reserved;
      logic [4:0] sys_mult;
      logic [3:0] system_pll_multiplier;
   } scgu_status_t;
endpackage
`default_nettype wire

// *** src/scgu_top.sv ***
// Clock generation and distribution unit with strap capture and Wishbone registers.
// How it works
// RL1 - Host role uses host reference clock input
// RL2 - Agent role uses agent clock input
// RL3 - Halve strap picks sync output divide
// RL4 - Each bus clock output halved by own bit
// RL5 - System clock ratio: multiplier times halve factor
// RL6 - Core setting taken from captured config word
// RL7 - Memory clock doubled, pair is its half
// RL8 - Local unit clock doubled, then divided
// RL9 - Unit ratios default at reset, software changes
// RL10 - Six units default third, bus full
// RL11 - Configurer keeps frequencies inside limits
// RL12 - Software keeps security, USB under limit
// RL13 - Board holds ethernet strap bit high
// RL14 - Multiplier 0 means sixteen, 1 reserved
// RL15 - Local clock is half, quarter or eighth
// RL16 - Ratio changes only on phase boundary
// RL17 - Derived clocks stopped until PLL lock
`default_nettype none
module scgu_top #(
   parameter int NUM_BUS_CLK = 5,
   parameter int NUM_LCLK    = 3
) (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [7:0]               wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic      [31:0]              wb_dat_o,
   output logic                          wb_ack_o,
   input  wire logic                     host_role_strap_i,
   input  wire logic                     input_halve_strap_i,
   input  wire logic [31:0]              reset_config_word_low_i,
   input  wire logic                     host_reference_clock_i,
   input  wire logic                     agent_clock_i,
   input  wire logic                     sys_pll_lock_i,
   output logic                          sync_loop_out_o,
   output logic      [NUM_BUS_CLK-1:0]   bus_clock_outputs_o,
   output logic      [4:0]               system_pll_multiplier_o,
   output logic                          system_pll_multiplier_reserved_o,
   output logic      [5:0]               csb_over_sync_o,
   output logic      [6:0]               core_pll_setting_o,
   output logic      [5:0]               mem_ctrl_mult_o,
   output logic      [5:0]               lbiu_mult_o,
   output logic                          memory_bus_clock_pair_p_o,
   output logic                          memory_bus_clock_pair_n_o,
   output logic                          local_sync_output_o,
   output logic      [NUM_LCLK-1:0]      local_bus_clock_outputs_o,
   output logic      [scgu_pkg::NUM_UNITS-1:0] unit_clk_en_o,
   output logic                          unit_rst_o
);
   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (NUM_BUS_CLK < 1 || NUM_BUS_CLK > 16) begin : g_bad_bus
      $error("NUM_BUS_CLK must lie in 1..16");
   end
   if (NUM_LCLK < 1) begin : g_bad_lclk
      $error("NUM_LCLK must be at least 1");
   end

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Zero means sixteen; one is reserved and reads as zero multiply.
   function automatic logic [4:0] system_pll_multiplier_decode(input logic [3:0] f);
      if (f == scgu_pkg::SYSTEM_PLL_MULTIPLIER_X16) begin
         return scgu_pkg::MULT_16;
      end
      else if (f == scgu_pkg::SYSTEM_PLL_MULTIPLIER_RSVD) begin
         return 5'h00;
      end
      return {1'b0, f};
   endfunction

   // Unit enable pattern over a six phase frame shared by all ratios.
   function automatic logic ratio_tick(input logic [1:0] r, input logic [2:0] ph);
      case (r)
         scgu_pkg::RATIO_FULL:  return 1'b1;
         scgu_pkg::RATIO_HALF:  return ~ph[0];
         scgu_pkg::RATIO_THIRD: return (ph == 3'h0) || (ph == scgu_pkg::PHASE_THIRD);
         default:               return 1'b0;
      endcase
   endfunction

   // Byte lane merge for Wishbone writes.
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      logic [31:0] m;
      m = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            m[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return m;
   endfunction

   // ****************************************************************
   // Strap and configuration word capture
   // ****************************************************************
   typedef enum logic [1:0] {ST_CAPTURE, ST_WAIT_LOCK, ST_RUN} scgu_state_t;

   scgu_state_t         state_reg, state_next;
   scgu_pkg::scgu_rcw_t rcw_reg,   rcw_next;
   logic                host_reg,  host_next;
   logic                halve_reg, halve_next;
   logic                run;

   // Straps are caught in the first cycle after reset release, never under reset.
   always_comb begin
      state_next = state_reg;
      rcw_next   = rcw_reg;
      host_next  = host_reg;
      halve_next = halve_reg;
      case (state_reg)
         ST_CAPTURE: begin
            rcw_next   = scgu_pkg::scgu_rcw_t'(reset_config_word_low_i); // [RL6]
            host_next  = host_role_strap_i;
            halve_next = input_halve_strap_i;
            state_next = ST_WAIT_LOCK;
         end
         ST_WAIT_LOCK: begin
            if (sys_pll_lock_i) begin
               state_next = ST_RUN; // [RL17]
            end
         end
         ST_RUN: begin
            if (!sys_pll_lock_i) begin
               state_next = ST_WAIT_LOCK; // [RL17]
            end
         end
         default: state_next = ST_CAPTURE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_CAPTURE;
         rcw_reg   <= '0;
         host_reg  <= 1'b0;
         halve_reg <= 1'b0;
      end
      else begin
         state_reg <= state_next;
         rcw_reg   <= rcw_next;
         host_reg  <= host_next;
         halve_reg <= halve_next;
      end
   end

   // Derived clocks run only with a captured word and a locked PLL.
   assign run = (state_reg == ST_RUN) && sys_pll_lock_i; // [RL17]

   // Ratio figures follow straight from the captured fields.
   assign system_pll_multiplier_o = system_pll_multiplier_decode(rcw_reg.system_pll_multiplier); // [RL14]
   assign system_pll_multiplier_reserved_o         = (rcw_reg.system_pll_multiplier == scgu_pkg::SYSTEM_PLL_MULTIPLIER_RSVD); // [RL14]
   assign csb_over_sync_o         = {1'b0, system_pll_multiplier_o} << halve_reg; // [RL5]
   assign core_pll_setting_o      = rcw_reg.core_pll; // [RL6]
   assign mem_ctrl_mult_o         = {1'b0, system_pll_multiplier_o} << rcw_reg.mem_doubler; // [RL7]
   assign lbiu_mult_o             = {1'b0, system_pll_multiplier_o} << rcw_reg.lbiu_doubler; // [RL8]

   // ****************************************************************
   // Wishbone register file
   // ****************************************************************
   logic [NUM_BUS_CLK-1:0] occr_reg, occr_next;
   logic [13:0]            sccr_reg, sccr_next;
   logic [1:0]             lccr_reg, lccr_next;
   logic [31:0]            dat_reg,  dat_next;
   logic                   ack_reg,  ack_next;
   logic [31:0]            rd_word;
   logic [31:0]            wr_word;
   scgu_pkg::scgu_status_t status;
   logic                   wr_go;

   always_comb begin
      status               = '0;
      status.core_pll      = rcw_reg.core_pll;
      status.halve_strap   = halve_reg;
      status.host_role     = host_reg;
      status.running       = run;
      status.mem_doubler   = rcw_reg.mem_doubler;
      status.lbiu_doubler  = rcw_reg.lbiu_doubler;
      status.system_pll_multiplier_reserved = system_pll_multiplier_reserved_o;
      status.sys_mult      = system_pll_multiplier_o;
      status.system_pll_multiplier          = rcw_reg.system_pll_multiplier;
   end

   // Read mux; unmapped addresses answer with zero so the bus never hangs.
   always_comb begin
      case (wb_adr_i)
         scgu_pkg::OFS_OUT_HALVE:  rd_word = 32'(occr_reg);
         scgu_pkg::OFS_UNIT_RATIO: rd_word = 32'(sccr_reg);
         scgu_pkg::OFS_LB_DIVIDER: rd_word = 32'(lccr_reg);
         scgu_pkg::OFS_STATUS:     rd_word = status;
         scgu_pkg::OFS_RATIOS:     rd_word = {10'h000, mem_ctrl_mult_o, 2'h0,
                                              lbiu_mult_o, 2'h0, csb_over_sync_o};
         default:                  rd_word = 32'h0000_0000;
      endcase
   end

   assign wr_go   = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;
   assign wr_word = lane_merge(rd_word, wb_dat_i, wb_sel_i);

   // One wait state: ack rises the cycle after the request, drops the next.
   always_comb begin
      ack_next  = wb_cyc_i && wb_stb_i && !ack_reg;
      dat_next  = ack_next ? rd_word : dat_reg;
      occr_next = occr_reg;
      sccr_next = sccr_reg;
      lccr_next = lccr_reg;
      if (wr_go && wb_adr_i == scgu_pkg::OFS_OUT_HALVE) begin
         occr_next = wr_word[NUM_BUS_CLK-1:0]; // [RL4]
      end
      if (wr_go && wb_adr_i == scgu_pkg::OFS_UNIT_RATIO) begin
         sccr_next = wr_word[13:0]; // [RL9]
         // The bus and DMA complex only knows off and full.
         if (wr_word[2*scgu_pkg::UNIT_PCI+1]) begin
            sccr_next[2*scgu_pkg::UNIT_PCI +: 2] = sccr_reg[2*scgu_pkg::UNIT_PCI +: 2]; // [RL10]
         end
      end
      // Encoding three is not a divider and leaves the setting alone.
      if (wr_go && wb_adr_i == scgu_pkg::OFS_LB_DIVIDER && wr_word[1:0] != 2'h3) begin
         lccr_next = wr_word[1:0]; // [RL15]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         occr_reg <= '0;
         sccr_reg <= scgu_pkg::UNIT_RATIO_RST; // [RL10]
         lccr_reg <= scgu_pkg::LB_DIV2;
         dat_reg  <= '0;
         ack_reg  <= 1'b0;
      end
      else begin
         occr_reg <= occr_next;
         sccr_reg <= sccr_next;
         lccr_reg <= lccr_next;
         dat_reg  <= dat_next;
         ack_reg  <= ack_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   // ****************************************************************
   // Primary clock selection and bus clock outputs
   // ****************************************************************
   logic                   prim;
   logic                   prim_prev_reg, prim_prev_next;
   logic                   half_reg,      half_next;
   logic                   sync_reg,      sync_next;
   logic [NUM_BUS_CLK-1:0] bus_reg,       bus_next;

   // The halved clock toggles on each rising edge of the chosen input.
   always_comb begin
      prim           = host_reg ? host_reference_clock_i : agent_clock_i; // [RL1] [RL2]
      prim_prev_next = prim;
      half_next      = (prim && !prim_prev_reg) ? !half_reg : half_reg; // [RL1]
      sync_next      = halve_reg ? half_next : prim; // [RL3]
      for (int i = 0; i < NUM_BUS_CLK; i++) begin
         bus_next[i] = occr_reg[i] ? half_next : prim; // [RL4]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prim_prev_reg <= 1'b0;
         half_reg      <= 1'b0;
         sync_reg      <= 1'b0;
         bus_reg       <= '0;
      end
      else begin
         prim_prev_reg <= prim_prev_next;
         half_reg      <= half_next;
         sync_reg      <= sync_next;
         bus_reg       <= bus_next;
      end
   end

   assign sync_loop_out_o     = sync_reg;
   assign bus_clock_outputs_o = bus_reg;

   // ****************************************************************
   // Memory pair, local bus divider and unit clock enables
   // ****************************************************************
   logic [2:0]                     phase_reg, phase_next;
   logic [13:0]                    act_reg,   act_next;
   logic [scgu_pkg::NUM_UNITS-1:0] en_reg,    en_next;
   logic                           mck_reg,   mck_next;
   logic [2:0]                     lbc_reg,   lbc_next;
   logic [1:0]                     lbd_reg,   lbd_next;
   logic                           lclk_reg,  lclk_next;

   // Ratio and divider settings are adopted only where every pattern restarts,
   // so no unit sees a shortened pulse; the cost is up to six cycles of latency for ratios and eight for the divider.
   always_comb begin
      phase_next = (!run || phase_reg == scgu_pkg::PHASE_LAST) ? 3'h0 : phase_reg + 3'h1;
      act_next   = (phase_reg == scgu_pkg::PHASE_LAST || !run) ? sccr_reg : act_reg; // [RL16]
      for (int u = 0; u < scgu_pkg::NUM_UNITS; u++) begin
         en_next[u] = run && ratio_tick(act_next[2*u +: 2], phase_next); // [RL9] [RL10]
      end
      mck_next  = run && !mck_reg; // [RL7]
      lbc_next  = run ? lbc_reg + 3'h1 : 3'h0;
      lbd_next  = (lbc_reg == scgu_pkg::LB_CNT_LAST || !run) ? lccr_reg : lbd_reg; // [RL16]
      case (lbd_next)
         scgu_pkg::LB_DIV4: lclk_next = run && lbc_next[1]; // [RL15]
         scgu_pkg::LB_DIV8: lclk_next = run && lbc_next[2]; // [RL15]
         default:           lclk_next = run && lbc_next[0]; // [RL8]
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_reg <= 3'h0;
         act_reg   <= scgu_pkg::UNIT_RATIO_RST;
         en_reg    <= '0;
         mck_reg   <= 1'b0;
         lbc_reg   <= 3'h0;
         lbd_reg   <= scgu_pkg::LB_DIV2;
         lclk_reg  <= 1'b0;
      end
      else begin
         phase_reg <= phase_next;
         act_reg   <= act_next;
         en_reg    <= en_next;
         mck_reg   <= mck_next;
         lbc_reg   <= lbc_next;
         lbd_reg   <= lbd_next;
         lclk_reg  <= lclk_next;
      end
   end

   assign memory_bus_clock_pair_p_o = mck_reg;
   assign memory_bus_clock_pair_n_o = run && !mck_reg; // [RL7]
   assign local_sync_output_o       = lclk_reg;
   assign local_bus_clock_outputs_o = {NUM_LCLK{lclk_reg}};
   assign unit_clk_en_o             = en_reg;
   assign unit_rst_o                = !run; // [RL17]

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   host_source_a: assert property ( // [RL1]
      (state_reg == ST_RUN && host_reg && !halve_reg) |=> sync_loop_out_o == $past(host_reference_clock_i))
      else $error("sync output does not follow host reference in host role");
   agent_source_a: assert property ( // [RL2]
      (state_reg == ST_RUN && !host_reg && !halve_reg) |=> sync_loop_out_o == $past(agent_clock_i))
      else $error("sync output does not follow agent clock in agent role");
   halve_toggle_a: assert property ( // [RL3]
      (state_reg == ST_RUN && halve_reg && prim && !prim_prev_reg) |=> $changed(sync_loop_out_o))
      else $error("halved sync output missed a toggle");
   multiplier_decode_a: assert property ( // [RL14]
      rcw_reg.system_pll_multiplier == scgu_pkg::SYSTEM_PLL_MULTIPLIER_X16 |-> system_pll_multiplier_o == 5'h10 && !system_pll_multiplier_reserved_o)
      else $error("multiplier code zero not decoded as sixteen");
   csb_ratio_a: assert property ( // [RL5]
      halve_reg |-> csb_over_sync_o == {system_pll_multiplier_o, 1'b0})
      else $error("system clock ratio ignores halve strap");
   core_capture_a: assert property ( // [RL6]
      state_reg == ST_CAPTURE |=> core_pll_setting_o == $past(reset_config_word_low_i[22:16]))
      else $error("core setting not taken from configuration word");
   mem_pair_a: assert property ( // [RL7]
      run ##1 run |-> $changed(memory_bus_clock_pair_p_o) &&
                      memory_bus_clock_pair_n_o == !memory_bus_clock_pair_p_o)
      else $error("memory clock pair not a complementary half rate clock");
   stopped_clocks_a: assert property ( // [RL17]
      !run |-> unit_rst_o ##1
         (unit_clk_en_o == '0 && !memory_bus_clock_pair_p_o && !local_sync_output_o))
      else $error("derived clocks run before lock");
   reset_default_a: assert property ( // [RL10]
      $fell(rst_i) |-> sccr_reg == 14'h1fff)
      else $error("unit ratios not at defaults after reset");
   third_pattern_a: assert property ( // [RL9]
      (unit_clk_en_o[0] && act_reg[1:0] == scgu_pkg::RATIO_THIRD && run)
         |=> !unit_clk_en_o[0] ##1 !unit_clk_en_o[0])
      else $error("third ratio unit ticked too often");
   boundary_change_a: assert property ( // [RL16]
      (run && $past(run) && $changed(act_reg)) |-> phase_reg == 3'h0)
      else $error("unit ratio changed inside a frame");
   local_div_a: assert property ( // [RL15]
      (run && lbd_reg == scgu_pkg::LB_DIV8 && $rose(local_sync_output_o))
         |=> local_sync_output_o [*3])
      else $error("eighth local clock high phase too short");

   run_start_c: cover property ($rose(run));
   ratio_full_c: cover property (run && act_reg[1:0] == scgu_pkg::RATIO_FULL);
   lb_div4_c: cover property (run && lbd_reg == scgu_pkg::LB_DIV4);
   reg_write_c: cover property (wr_go && wb_adr_i == scgu_pkg::OFS_UNIT_RATIO);
endmodule
`default_nettype wire

// *** tb/scgu_osc_model.sv ***
// Model of the reference oscillator, the agent clock and the system PLL lock.
`default_nettype none
module scgu_osc_model #(
   parameter bit HOST_ROLE = 1'b1
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   output var  logic host_reference_clock_o,
   output var  logic agent_clock_o,
   output var  logic sys_pll_lock_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt;
   // ****************************************************************
   // Clock sources
   // ****************************************************************
   // Reference is four system cycles long and offset by 3 ns so sampling never races.
   initial begin
      host_reference_clock_o = 1'b0;
      #3;
      forever #20 host_reference_clock_o = HOST_ROLE ? ~host_reference_clock_o : 1'b0;
   end
   // Agent clock runs at a different rate so a wrong source choice shows up.
   initial begin
      agent_clock_o = 1'b0;
      #3;
      forever #60 agent_clock_o = ~agent_clock_o;
   end
   // Lock comes 31 cycles after reset leaves, as a real loop needs time to settle.
   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 0;
         sys_pll_lock_o <= 1'b0;
      end else if (cnt < 30) begin
         cnt <= cnt + 1;
      end else begin
         sys_pll_lock_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** tb/system_clock_generation_unit_tb.sv ***
// Self-checking testbench of the clock generation unit.
`default_nettype none
module system_clock_generation_unit_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] RCW = 32'h402a0000;
   localparam int DEF_CNT[7] = '{32, 32, 32, 32, 32, 32, 96};
   localparam int NEW_CNT[7] = '{0, 96, 48, 32, 96, 0, 96};
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        hs = 1'b1, hv = 1'b1;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic        ack, href, aclk, lock, sync, mp, mn, lsync, urst;
   logic [4:0]  bus, spm;
   logic [2:0]  lclk;
   logic [6:0]  en;
   logic [3:0]  ck, ck_q;
   int          bad_count = 0, n_tests = 0, rise[4], high[7], dr[4], dh[7];
   assign ck = {lsync, bus[1:0], sync};
   // ****************************************************************
   // Clock, partner and device
   // ****************************************************************
   initial forever #5 clk_i = ~clk_i;
   scgu_osc_model i_osc (.clk_i(clk_i), .rst_i(rst_i), .host_reference_clock_o(href),
      .agent_clock_o(aclk), .sys_pll_lock_o(lock));
   scgu_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .host_role_strap_i(hs), .input_halve_strap_i(hv), .reset_config_word_low_i(RCW),
      .host_reference_clock_i(hs ? href : 1'b0), // Grounded in agent role.
      .agent_clock_i(aclk), .sys_pll_lock_i(lock),
      .sync_loop_out_o(sync), .bus_clock_outputs_o(bus), .system_pll_multiplier_o(spm),
      .system_pll_multiplier_reserved_o(), .csb_over_sync_o(), .core_pll_setting_o(), .mem_ctrl_mult_o(),
      .lbiu_mult_o(), .memory_bus_clock_pair_p_o(mp), .memory_bus_clock_pair_n_o(mn),
      .local_sync_output_o(lsync), .local_bus_clock_outputs_o(lclk), .unit_clk_en_o(en),
      .unit_rst_o(urst));
   // Counts clock rises and enable cycles; tasks read them on the falling edge.
   always @(posedge clk_i) begin
      ck_q <= ck;
      foreach (rise[i]) if (ck[i] === 1'b1 && ck_q[i] === 1'b0) rise[i]++;
      foreach (high[i]) if (en[i] === 1'b1) high[i]++;
   end
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Classic single cycle; the request stands until ack is sampled high.
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 100);
      if (k >= 100) begin
         bad_count++;
      end
      q = rdat;
      {cyc, stb} <= 2'b00;
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task measure;
      int a[4], b[7];
      @(negedge clk_i);
      a = rise;
      b = high;
      repeat (96) @(negedge clk_i);
      foreach (dr[i]) dr[i] = rise[i] - a[i];
      foreach (dh[i]) dh[i] = high[i] - b[i];
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task t_startup;
      int k;
      k = 0;
      @(negedge clk_i);
      chk({31'h0, urst}, 32'h1);
      chk({25'h0, en}, 32'h0);
      while (urst !== 1'b0 && k < 100) begin
         @(negedge clk_i);
         k++;
      end
      chk({31'h0, urst}, 32'h0);
   endtask
   task t_regs;
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h04, 32'h1fff);
      rd_chk(8'h08, 32'h0);
      rd_chk(8'h14, 32'h0);
      wb(1'b1, 8'h0c, 32'hffffffff);
      rd_chk(8'h0c, 32'h002a7900);
      rd_chk(8'h10, 32'h00201020);
      chk({27'h0, spm}, 32'h10);
   endtask
   task t_units;
      measure();
      foreach (dh[i]) chk(32'(dh[i]), 32'(DEF_CNT[i]));
      wb(1'b1, 8'h04, 32'h21e4); // Security and USB kept at or below a third.
      rd_chk(8'h04, 32'h11e4);
      repeat (12) @(posedge clk_i);
      measure();
      foreach (dh[i]) chk(32'(dh[i]), 32'(NEW_CNT[i]));
      chk({31'h0, mn}, {31'h0, ~mp});
   endtask
   task t_lbdiv;
      for (int d = 0; d < 3; d++) begin
         wb(1'b1, 8'h08, 32'(d));
         repeat (16) @(posedge clk_i);
         measure();
         chk(32'(dr[3]), 32'(48 >> d));
      end
      wb(1'b1, 8'h08, 32'h3);
      rd_chk(8'h08, 32'h2);
   endtask
   task t_busclk;
      wb(1'b1, 8'h00, 32'h01);
      rd_chk(8'h00, 32'h01);
      repeat (4) @(posedge clk_i);
      measure();
      chk(32'(dr[0]), 32'd12);
      chk(32'(dr[1]), 32'd12);
      chk(32'(dr[2]), 32'd24);
   endtask
   // Mid-run reset with new straps; n is the expected sync rises per window.
   task t_restart(input logic h, input logic v, input int n, input logic [31:0] s);
      @(posedge clk_i);
      rst_i <= 1'b1;
      {hs, hv} <= {h, v};
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_startup();
      rd_chk(8'h0c, s);
      rd_chk(8'h10, 32'h00201010);
      measure();
      chk(32'(dr[0]), 32'(n));
   endtask
   // ****************************************************************
   // Verdict, watchdog and main sequence
   // ****************************************************************
   task final_report;
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // The whole run needs just over a thousand cycles; twenty thousand means a hang.
   initial begin
      #200us;
      bad_count++;
      final_report();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0; // The board keeps the ethernet strap bit high through reset.
      t_startup();
      t_regs();
      t_units();
      t_lbdiv();
      t_busclk();
      t_restart(1'b1, 1'b0, 24, 32'h002a3900);
      t_restart(1'b0, 1'b0, 8, 32'h002a1900);
      final_report();
   end
endmodule
`default_nettype wire
